/* File: core/sdf_decim.sv */
/*
  Sinc3/sinc4 decimation filter with postfilter averaging, chopping and
  an optional 60 Hz notch, reached over APB.
  Assumes pclk is the 4.92 MHz master clock and one modulator bit arrives
  per clock, synchronous to pclk.
*/
`timescale 1ns/1ps
`include "sdf_defines.svh"

// Summary of operation
// R1 - With sinc3 and chop on, one result comes every 3 x 1024 x FS master clocks, FS from 1 to 1023.
// R2 - With chop on, settling takes two output periods; in fast settling chop doubles settling, not the rate.
// R3 - In chop sinc3 mode a channel change resets modulator and filter, the first result needs full settling.
// R4 - Through an input step chop mode keeps its rate and shows the step after two or three conversions.
// R5 - With chop on, the input pair is swapped each conversion and opposite conversions are averaged.
// R6 - Chopping places notches at odd multiples of half the output data rate.
// R7 - Chop sinc3 mode has a -3 dB cutoff at 0.24 times the output data rate.
// R8 - The sixty-hertz notch enable adds a 60 Hz notch and leaves the output rate unchanged.
// R9 - Fast settling inserts a postfilter averaging 2, 8 or 16 sinc outputs per the select bits.
// R10 - With both select bits zero, fast settling is off and its rate equation does not apply.
// R11 - Select codes 01, 10 and 11 average by 2, 8 and 16.
// R12 - Fast settling sinc4 without chop gives one output every (4 + Avg - 1) x 1024 x FS clocks.
// R13 - In fast settling, settling equals one output period and channel switches add no latency.
// R14 - In fast settling a synchronous step gives settled results, an asynchronous one a single unsettled result.
// R15 - The sinc notch lies at mclk / (1024 x FS) and the postfilter adds notches at that divided by Avg.
// R16 - All rates and settling times derive from the 4.92 MHz master clock.
module sdf_decim #(
  parameter int ACC_W = 84,
  parameter int RES_W = 32,
  parameter int CH_W  = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             mod_bit,
  output logic                  mod_reset,
  output logic                  input_swap,
  output logic [CH_W-1:0]       channel_sel,
  output logic                  result_valid,
  output logic [RES_W-1:0]      result_data
);

  // ****************************************
  // Register bus
  // ****************************************
  sdf_pkg::sdf_cfg_s    cfg_q;
  sdf_pkg::sdf_state_e  state_q;
  logic                 acc_en;
  logic                 wr_en;
  logic                 rd_en;
  logic                 hit;
  logic                 ready_q;
  logic                 settled_q;
  logic                 done_pulse;
  logic                 chan_wr;
  logic                 ctrl_wr;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  assign acc_en  = psel & penable;
  assign wr_en   = acc_en & pwrite;
  assign rd_en   = acc_en & ~pwrite;
  assign hit     = is_addr(paddr, `SDF_OFF_CTRL) | is_addr(paddr, `SDF_OFF_CHAN) |
                   is_addr(paddr, `SDF_OFF_STATUS) | is_addr(paddr, `SDF_OFF_DATA);
  assign pready  = 1'b1;
  assign pslverr = acc_en & ~hit;
  assign ctrl_wr = wr_en & is_addr(paddr, `SDF_OFF_CTRL);
  assign chan_wr = wr_en & is_addr(paddr, `SDF_OFF_CHAN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= sdf_pkg::sdf_cfg_s'(16'(`SDF_CTRL_RESET));
    end else if (ctrl_wr) begin
      cfg_q <= sdf_pkg::sdf_cfg_s'(pwdata[`SDF_CTRL_EN:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_sel <= '0;
    end else if (chan_wr) begin
      channel_sel <= pwdata[CH_W-1:0];
    end
  end

  // Set wins over the clear from a data read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else if (done_pulse) begin
      ready_q <= 1'b1;
    end else if (rd_en && is_addr(paddr, `SDF_OFF_DATA)) begin
      ready_q <= 1'b0;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (is_addr(paddr, `SDF_OFF_CTRL)) begin
      prdata = 32'(cfg_q);
    end else if (is_addr(paddr, `SDF_OFF_CHAN)) begin
      prdata = 32'(channel_sel);
    end else if (is_addr(paddr, `SDF_OFF_STATUS)) begin
      prdata = {27'h000_0000, input_swap, settled_q, state_q, ready_q};
    end else if (is_addr(paddr, `SDF_OFF_DATA)) begin
      prdata = 32'(result_data);
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  logic        fast;
  logic [4:0]  order;
  logic [4:0]  avg_n;
  logic [2:0]  avg_sh;
  logic [4:0]  conv_len;
  logic [9:0]  fs_eff;
  logic [19:0] dec_last;
  logic [19:0] notch_pt;
  logic [22:0] notch_prod;

  assign fast  = |cfg_q.avg_sel; // R10
  assign order = cfg_q.sinc3 ? `SDF_ORDER3 : `SDF_ORDER4;

  always_comb begin
    avg_n  = `SDF_AVG2;
    avg_sh = `SDF_AVG2_SH;
    if (cfg_q.avg_sel == 2'b10) begin // R11
      avg_n  = `SDF_AVG8;
      avg_sh = `SDF_AVG8_SH;
    end else if (cfg_q.avg_sel == 2'b11) begin
      avg_n  = `SDF_AVG16;
      avg_sh = `SDF_AVG16_SH;
    end
  end

  // Sinc outputs per conversion: order alone, or order + Avg - 1
  assign conv_len = fast ? 5'(order + avg_n - 5'h01) : order; // R1 R12

  // FS of zero would stall the divider, so it runs as one
  assign fs_eff     = (cfg_q.fs == 10'h000) ? 10'h001 : cfg_q.fs;
  assign dec_last   = 20'({fs_eff, 10'h000} - 20'h0_0001); // R15 R16
  assign notch_prod = 23'({fs_eff, 10'h000} * `SDF_NOTCH_NUM);
  assign notch_pt   = 20'(notch_prod / `SDF_NOTCH_DEN);

  // ****************************************
  // Sequencing
  // ****************************************
  logic [19:0] dec_q;
  logic        tick;
  logic        restart;
  logic [4:0]  ph_q;
  logic        conv_end;

  assign tick     = (state_q == sdf_pkg::SDF_RUN) && (dec_q == dec_last);
  assign conv_end = tick && (ph_q == 5'(conv_len - 5'h01));
  // Config or channel writes restart so the first result fully settles
  assign restart  = (state_q != sdf_pkg::SDF_RUN) | ~cfg_q.en | ctrl_wr | chan_wr | conv_end; // R3 R13
  assign mod_reset = restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sdf_pkg::SDF_IDLE;
    end else begin
      case (state_q)
        sdf_pkg::SDF_IDLE: begin
          if (cfg_q.en && !ctrl_wr) begin
            state_q <= sdf_pkg::SDF_RUN;
          end
        end
        sdf_pkg::SDF_RUN: begin
          if (!cfg_q.en) begin
            state_q <= sdf_pkg::SDF_IDLE;
          end
        end
        default: state_q <= sdf_pkg::SDF_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= '0;
    end else if (restart || tick) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_q + 20'h0_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= '0;
    end else if (restart) begin
      ph_q <= '0;
    end else if (tick) begin
      ph_q <= ph_q + 5'h01;
    end
  end

  // ****************************************
  // Integrators and combs
  // ****************************************
  logic signed [ACC_W-1:0] integ_q [4];
  logic signed [ACC_W-1:0] comb_d_q [4];
  logic signed [ACC_W-1:0] comb_v [5];
  logic signed [ACC_W-1:0] snap_q;
  logic signed [ACC_W-1:0] top;
  logic signed [ACC_W-1:0] bit_val;

  assign bit_val = {{(ACC_W-1){~mod_bit}}, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_int
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          integ_q[gi] <= '0;
        end else if (restart) begin
          integ_q[gi] <= '0;
        end else begin
          integ_q[gi] <= integ_q[gi] + ((gi == 0) ? bit_val : integ_q[(gi == 0) ? 0 : gi - 1]);
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          comb_d_q[gi] <= '0;
        end else if (restart) begin
          comb_d_q[gi] <= '0;
        end else if (tick) begin
          comb_d_q[gi] <= comb_v[gi];
        end
      end
      assign comb_v[gi+1] = comb_v[gi] - comb_d_q[gi];
    end
  endgenerate

  // Delayed copy of the integrator adds a zero at 60 Hz, rate untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= '0;
    end else if (restart) begin
      snap_q <= '0;
    end else if (dec_q == notch_pt) begin
      snap_q <= top;
    end
  end

  assign top       = cfg_q.sinc3 ? integ_q[2] : integ_q[3];
  assign comb_v[0] = cfg_q.notch ? top + snap_q : top; // R8

  // ****************************************
  // Postfilter and chop
  // ****************************************
  logic signed [ACC_W-1:0] sinc_out;
  logic signed [ACC_W-1:0] avg_acc_q;
  logic signed [ACC_W-1:0] avg_sum;
  logic signed [ACC_W-1:0] conv_val;
  logic signed [ACC_W-1:0] chop_val;
  logic signed [ACC_W-1:0] prev_q;
  logic signed [ACC_W-1:0] res_rnd;
  logic [5:0]              res_sh;
  logic                    have_prev_q;
  logic                    keep;

  // Raw sinc scaled by 2^-(10*order); gain of FS itself is left in
  // Notch copy doubles the gain, so one more bit of shift
  assign res_sh   = 6'(order * `SDF_DEC_SHIFT) + 6'(cfg_q.notch);
  // Round half up: a window started from zero falls one count short
  assign res_rnd  = ACC_W'(1'b1) <<< (res_sh - 6'h01);
  assign sinc_out = ((cfg_q.sinc3 ? comb_v[3] : comb_v[4]) + res_rnd) >>> res_sh; // R15
  // Sinc outputs before the filter has filled are discarded
  assign keep     = tick && (ph_q >= 5'(order - 5'h01));
  assign avg_sum  = avg_acc_q + sinc_out;
  assign conv_val = fast ? (avg_sum >>> avg_sh) : sinc_out; // R9
  assign chop_val = input_swap ? -conv_val : conv_val; // R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_acc_q <= '0;
    end else if (restart) begin
      avg_acc_q <= '0;
    end else if (keep) begin
      avg_acc_q <= avg_sum; // R9
    end
  end

  // Polarity swaps every conversion with chop on; a config or channel write, or leaving run, starts a fresh pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_swap  <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q      <= '0;
    end else if (ctrl_wr || chan_wr || state_q != sdf_pkg::SDF_RUN) begin
      input_swap  <= 1'b0; // R3
      have_prev_q <= 1'b0;
      prev_q      <= '0;
    end else if (conv_end && cfg_q.chop) begin
      input_swap  <= ~input_swap; // R5 R6
      have_prev_q <= 1'b1;
      prev_q      <= chop_val;
    end
  end

  // Chop needs two conversions per settled result, then one per period
  assign done_pulse = conv_end && (!cfg_q.chop || have_prev_q); // R2 R4 R14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_data <= '0;
      settled_q   <= 1'b0;
    end else if (ctrl_wr || chan_wr) begin
      settled_q <= 1'b0;
    end else if (done_pulse) begin
      result_data <= cfg_q.chop ? RES_W'((prev_q + chop_val) >>> 1) : RES_W'(conv_val); // R5 R7
      settled_q   <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= done_pulse; // R1 R12 R13
    end
  end

endmodule

/* File: core/sdf_defines.svh */
/*
  Constants for the decimation filter timing block: register offsets,
  field positions, reset values and divider figures.
  Assumes inclusion by bare name from the design file, the checker and the bench.
*/
`ifndef SDF_DEFINES_SVH
`define SDF_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SDF_OFF_CTRL      12'h000
`define SDF_OFF_CHAN      12'h004
`define SDF_OFF_STATUS    12'h008
`define SDF_OFF_DATA      12'h00C

// ****************************************
// Control fields
// ****************************************
`define SDF_CTRL_FS_LSB   0
`define SDF_CTRL_FS_MSB   9
`define SDF_CTRL_AVG_LO   10
`define SDF_CTRL_AVG_HI   11
`define SDF_CTRL_CHOP     12
`define SDF_CTRL_SINC3    13
`define SDF_CTRL_NOTCH    14
`define SDF_CTRL_EN       15
`define SDF_CTRL_RESET    32'h0000_0001

// ****************************************
// Divider and filter figures
// ****************************************
`define SDF_MCLK_KHZ      4920
`define SDF_DEC_SHIFT     10
`define SDF_NOTCH_NUM     23'h00_0005
`define SDF_NOTCH_DEN     23'h00_000C
`define SDF_ORDER3        5'h03
`define SDF_ORDER4        5'h04
`define SDF_AVG2          5'h02
`define SDF_AVG8          5'h08
`define SDF_AVG16         5'h10
`define SDF_AVG2_SH       3'h1
`define SDF_AVG8_SH       3'h3
`define SDF_AVG16_SH      3'h4

`endif

/* File: core/sdf_pkg.sv */
/*
  Types shared by the decimation filter timing block.
  Assumes sdf_defines.svh is on the include path.
*/
package sdf_pkg;
  typedef struct packed {
    logic       en;
    logic       notch;
    logic       sinc3;
    logic       chop;
    logic [1:0] avg_sel;
    logic [9:0] fs;
  } sdf_cfg_s;

  typedef enum logic [1:0] {
    SDF_IDLE = 2'b01,
    SDF_RUN  = 2'b10
  } sdf_state_e;
endpackage

/* File: sim/sdf_decim_chk.sv */
/*
  Port-level timing checker for sdf_decim.
  Assumes control and channel words change only through APB writes.
*/
`timescale 1ns/1ps
`include "sdf_defines.svh"
module sdf_chk #(
  parameter int RES_W = 32,
  parameter int CH_W  = 4
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  input wire logic             mod_reset,
  input wire logic             input_swap,
  input wire logic [CH_W-1:0]  channel_sel,
  input wire logic             result_valid,
  input wire logic [RES_W-1:0] result_data
);
  // ****************
  // Shadow state
  // ****************
  sdf_pkg::sdf_cfg_s cfg_q;
  logic              seen_q;
  int                cnt_q;
  int                per;
  int                set;
  wire logic         wr = psel && penable && pwrite;
  always_comb begin
    case (cfg_q.avg_sel)
      2'b00: per = 3;
      2'b01: per = 4;
      2'b10: per = 10;
      default: per = 18;
    endcase
    per = (per + int'(!cfg_q.sinc3)) * 1024 * (cfg_q.fs == 10'h000 ? 1 : int'(cfg_q.fs));
    set = cfg_q.chop ? 2 * per : per;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 16'h0001;
    end else if (wr && paddr == `SDF_OFF_CTRL) begin
      cfg_q <= pwdata[15:0];
    end
  end
  // Restarts clear the spacing count, so first and later results differ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 0;
      seen_q <= 1'b0;
    end else if (wr && (paddr == `SDF_OFF_CTRL || paddr == `SDF_OFF_CHAN)) begin
      cnt_q  <= 0;
      seen_q <= 1'b0;
    end else if (result_valid) begin
      cnt_q  <= 0;
      seen_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_chan_wr; wr && paddr == `SDF_OFF_CHAN; endsequence
  sequence s_res; result_valid && cfg_q.en; endsequence
  property p_gap; s_res ##0 seen_q |-> cnt_q == per - 1; endproperty
  a_gap: assert property (p_gap) else $error("result spacing wrong");
  property p_first; s_res ##0 !seen_q |-> cnt_q >= set - 2 && cnt_q <= set + 1; endproperty
  a_first: assert property (p_first) else $error("first result time wrong");
  property p_pulse; result_valid |=> !result_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("result pulse too long");
  property p_hold; $changed(result_data) |-> result_valid; endproperty
  a_hold: assert property (p_hold) else $error("result changed without pulse");
  property p_swap; !cfg_q.chop && !wr |=> $stable(input_swap); endproperty
  a_swap: assert property (p_swap) else $error("swap moved with chop off");
  property p_chan; s_chan_wr |-> mod_reset ##1 channel_sel == $past(pwdata[CH_W-1:0]); endproperty
  a_chan: assert property (p_chan) else $error("channel change not restarting");
  property p_idle; !cfg_q.en |-> mod_reset; endproperty
  a_idle: assert property (p_idle) else $error("filter not held while idle");
  property p_err; psel && penable && paddr > `SDF_OFF_DATA |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule
bind sdf_decim sdf_chk #(.RES_W(RES_W), .CH_W(CH_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .mod_reset(mod_reset), .input_swap(input_swap),
  .channel_sel(channel_sel), .result_valid(result_valid), .result_data(result_data)
);

/* File: sim/sdf_mod_src.sv */
/*
  Behavioural modulator giving a full-scale bitstream of either sign.
  Assumes the filter negates conversions taken with the pair swapped.
*/
`timescale 1ns/1ps
module sdf_mod_src (
  input  wire logic level_pos,
  input  wire logic input_swap,
  output logic      mod_bit
);
  // ****************
  // Bitstream
  // ****************
  // Swapping the pair flips the sign seen by the modulator
  assign mod_bit = level_pos ^ input_swap;
endmodule

/* File: sim/tb.sv */
/*
  Bench for sdf_decim: APB master, full-scale modulator, timing and value checks.
  Assumes FS = 1 throughout, so one sinc period is 1024 clocks.
*/
`timescale 1ns/1ps
`include "sdf_defines.svh"
module tb;
  localparam int P = 1024;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        mod_bit, mod_reset, input_swap, result_valid, level_pos, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, result_data, rd;
  logic [3:0]  channel_sel;
  int          fail_count, n_tests, cyc;
  sdf_decim dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .mod_bit(mod_bit),
    .mod_reset(mod_reset), .input_swap(input_swap), .channel_sel(channel_sel),
    .result_valid(result_valid), .result_data(result_data)
  );
  sdf_mod_src u_mod (.level_pos(level_pos), .input_swap(input_swap), .mod_bit(mod_bit));
  // ****************
  // Support tasks
  // ****************
  always #5 pclk = ~pclk;
  // Longest run is near 96k cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 120000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Leading edge keeps two transfers from driving psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_res(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (result_valid !== 1'b1);
  endtask
  function automatic logic [31:0] cfg(input logic nt, input logic s3, input logic ch, input logic [1:0] av);
    sdf_pkg::sdf_cfg_s c;
    c = '{1'b1, nt, s3, ch, av, 10'h001};
    return {16'h0000, c};
  endfunction
  task automatic run_cfg(input logic [31:0] w, input int l, input int k, input int gaps, input bit step);
    int n;
    level_pos <= 1'b1;
    apb(1'b1, `SDF_OFF_CTRL, w);
    wait_res(n);
    chk("first_lat", {31'h0, n >= k * l * P - 1 && n <= k * l * P + 2}, 32'h0000_0001);
    chk("first_val", result_data, 32'h0000_0001);
    for (int i = 0; i < gaps; i++) begin
      if (step && i == 0) begin
        repeat (100) @(posedge pclk);
        level_pos <= 1'b0;
      end
      wait_res(n);
      if (!step || i > 0) chk("gap", n, l * P);
    end
    if (step) chk("step_val", result_data, 32'hFFFF_FFFF);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    apb(1'b0, `SDF_OFF_CTRL, 32'h0000_0000);
    chk("ctrl_rst", rd, `SDF_CTRL_RESET);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk("bad_err", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("bad_rd", rd, 32'h0000_0000);
    apb(1'b1, `SDF_OFF_CHAN, 32'h0000_0005);
    @(posedge pclk);
    chk("chan_sel", {28'h0, channel_sel}, 32'h0000_0005);
  endtask
  task automatic t_rates();
    run_cfg(cfg(1'b0, 1'b1, 1'b0, 2'b00), 3, 1, 1, 1'b0);
    run_cfg(cfg(1'b1, 1'b0, 1'b0, 2'b00), 4, 1, 1, 1'b0);
    run_cfg(cfg(1'b0, 1'b0, 1'b0, 2'b01), 5, 1, 2, 1'b1);
    run_cfg(cfg(1'b0, 1'b0, 1'b0, 2'b10), 11, 1, 0, 1'b0);
    run_cfg(cfg(1'b0, 1'b0, 1'b0, 2'b11), 19, 1, 0, 1'b0);
    run_cfg(cfg(1'b0, 1'b0, 1'b1, 2'b01), 5, 2, 0, 1'b0);
    run_cfg(cfg(1'b0, 1'b1, 1'b1, 2'b00), 3, 2, 3, 1'b1);
  endtask
  // Mid-conversion channel change while chopping sinc3
  task automatic t_chan();
    int   n;
    logic s;
    repeat (500) @(posedge pclk);
    apb(1'b1, `SDF_OFF_CHAN, 32'h0000_0003);
    wait_res(n);
    chk("chan_lat", {31'h0, n >= 6 * P - 1 && n <= 6 * P + 2}, 32'h0000_0001);
    chk("chan_val", result_data, 32'hFFFF_FFFF);
    s = input_swap;
    wait_res(n);
    chk("swap", {31'h0, input_swap}, {31'h0, ~s});
    // Status: swap, settled, run state, ready; a data read clears ready
    apb(1'b0, `SDF_OFF_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0000_001D);
    apb(1'b0, `SDF_OFF_DATA, 32'h0000_0000);
    chk("data_rd", rd, 32'hFFFF_FFFF);
    apb(1'b0, `SDF_OFF_STATUS, 32'h0000_0000);
    chk("ready_clr", rd, 32'h0000_001C);
  endtask
  initial begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    level_pos = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rates();
    t_chan();
    test_done();
  end
endmodule
